/* File: design/tmr2_baud_clkout.sv */
// Purpose: baud-rate generator and clock output of a 16-bit reloading timer
// Assumes: clk_i is the oscillator; count inputs synchronous to clk_i
// Notes: capture and plain auto-reload modes are not covered
// Notes on behaviour
// - either transmit or receive select set puts the timer in baud mode
// - serial port takes tx tick when transmit select, rx tick when receive select
// - baud-mode rollover reloads both count bytes from the reload pair
// - baud mode counts every state time; ordinary timer every twelfth oscillator
// - serial bit rate is osc over 32 times (65536 minus reload)
// - baud-mode rollover sets no overflow flag and raises no interrupt
// - with trigger enable, falling trigger pin sets external flag, no reload
// - clock output active when counter select clear and output enable set
// - run control starts and stops the timer, clock output included
// - clock pin is 50% duty at osc over 4 times (65536 minus reload)
// - without clock output the pin stays ordinary I/O or count input
// - clock-output rollovers raise no interrupt
// - baud and clock output run together from the one reload value
// - timer interrupt request is overflow flag OR external flag
// - flags are never cleared by hardware on vectoring, only by software
// - request passes only with the timer interrupt enable set
// - global enable clear blocks every interrupt
//
// The address map and the address-and-strobe port were decided locally.
`timescale 1ns/1ps
module tmr2_baud_clkout #(
  parameter int STATE_DIV = tmr2_pkg::STATE_TIME_OSC,
  parameter int MACHINE_DIV = tmr2_pkg::MACHINE_CYCLE_OSC
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic [2:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  input wire logic ext_trigger_pin_i,
  input wire logic count_pin_i,
  input wire logic port_latch_i,
  output logic clock_output_pin_o,
  output logic clock_output_pin_oe_o,
  output logic tx_tick_o,
  output logic rx_tick_o,
  output logic irq_o
);
  initial
  begin
    if (STATE_DIV < 1 || MACHINE_DIV < STATE_DIV || MACHINE_DIV > 255)
      $error("tmr2_baud_clkout: unsupported divider values");
  end

  logic [7:0] control_r;
  logic [7:0] mode_r;
  logic [7:0] ie_r;
  logic [15:0] reload_r;
  logic [15:0] count_r;
  logic [7:0] pre_r;
  logic trig_d_r;
  logic cnt_d_r;
  logic clk_out_r;
  logic oe_r;
  logic tx_r;
  logic rx_r;
  logic [7:0] rdata_r;
  logic baud_mode;
  logic clkout_mode;
  logic inc;
  logic rollover;
  logic trig_fall;
  logic ovf_set;
  logic [7:0] pre_lim;
  tmr2_pkg::run_mode_t mode_now;

  assign baud_mode = control_r[tmr2_pkg::CTL_RCLK] | control_r[tmr2_pkg::CTL_TRANSMIT_RATE_SELECT];
  assign clkout_mode = ~control_r[tmr2_pkg::CTL_CT] & mode_r[tmr2_pkg::MOD_OE];
  // clock-out and baud both tick at the state time, so they share one prescale
  assign pre_lim = (baud_mode | clkout_mode) ? 8'(STATE_DIV - 1) : 8'(MACHINE_DIV - 1);
  assign trig_fall = trig_d_r & ~ext_trigger_pin_i;

  always_comb
  begin
    if (!control_r[tmr2_pkg::CTL_RUN])
      mode_now = tmr2_pkg::MODE_OFF;
    else if (baud_mode | clkout_mode)
      mode_now = tmr2_pkg::MODE_BAUD;
    else
      mode_now = tmr2_pkg::MODE_TIMER;
  end

  always_comb
  begin
    case (mode_now)
      tmr2_pkg::MODE_OFF: inc = 1'b0;
      tmr2_pkg::MODE_BAUD: inc = (pre_r == pre_lim);
      tmr2_pkg::MODE_TIMER:
        inc = control_r[tmr2_pkg::CTL_CT] ? (cnt_d_r & ~count_pin_i) : (pre_r == pre_lim);
      default: inc = 1'b0;
    endcase
  end

  assign rollover = inc & (count_r == 16'hFFFF);
  // overflow flag only outside baud and clock-out use
  assign ovf_set = rollover & ~baud_mode & ~clkout_mode;

  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      pre_r <= 8'h00;
    else if (!control_r[tmr2_pkg::CTL_RUN] || pre_r == pre_lim)
      pre_r <= 8'h00;
    else
      pre_r <= pre_r + 8'h01;
  end

  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      trig_d_r <= 1'b1;
      cnt_d_r <= 1'b1;
    end
    else
    begin
      trig_d_r <= ext_trigger_pin_i;
      cnt_d_r <= count_pin_i;
    end
  end

  // count: reload on every rollover; software writes lose to hardware
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      count_r <= 16'h0000;
    else if (rollover)
      count_r <= reload_r;
    else if (inc)
      count_r <= count_r + 16'h0001;
    else if (wr_i && addr_i == tmr2_pkg::ADDR_COUNT_LOW)
      count_r[7:0] <= wdata_i;
    else if (wr_i && addr_i == tmr2_pkg::ADDR_COUNT_HIGH)
      count_r[15:8] <= wdata_i;
  end

  // reload write mid-run may collide with a reload; software must stop first
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      reload_r <= tmr2_pkg::RELOAD_RESET;
    else if (wr_i && addr_i == tmr2_pkg::ADDR_RELOAD_LOW)
      reload_r[7:0] <= wdata_i;
    else if (wr_i && addr_i == tmr2_pkg::ADDR_RELOAD_HIGH)
      reload_r[15:8] <= wdata_i;
  end

  // flags: hardware set wins over a software clear in the same cycle
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      control_r <= tmr2_pkg::CONTROL_RESET;
    else
    begin
      if (wr_i && addr_i == tmr2_pkg::ADDR_CONTROL)
        control_r <= wdata_i;
      if (ovf_set)
        control_r[tmr2_pkg::CTL_OVF] <= 1'b1;
      if (trig_fall && control_r[tmr2_pkg::CTL_EXEN])
        control_r[tmr2_pkg::CTL_EXF] <= 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      mode_r <= tmr2_pkg::MODE_RESET;
      ie_r <= tmr2_pkg::IE_RESET;
    end
    else if (wr_i && addr_i == tmr2_pkg::ADDR_MODE)
      mode_r <= {6'h00, wdata_i[1:0]};
    else if (wr_i && addr_i == tmr2_pkg::ADDR_IRQ_ENABLE)
      ie_r <= {wdata_i[7], 1'b0, wdata_i[5:0]};
  end

  // one tick per rollover, osc/2/(65536-reload); the serial port's own
  // divide by 16 makes osc/32, so no extra divider sits here
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      tx_r <= 1'b0;
      rx_r <= 1'b0;
    end
    else
    begin
      tx_r <= rollover & control_r[tmr2_pkg::CTL_TRANSMIT_RATE_SELECT];
      rx_r <= rollover & control_r[tmr2_pkg::CTL_RCLK];
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      clk_out_r <= 1'b0;
    else if (!clkout_mode)
      clk_out_r <= port_latch_i;
    else if (rollover)
      clk_out_r <= ~clk_out_r;
  end

  // pin released only while it serves as the count input
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      oe_r <= 1'b1;
    else
      oe_r <= clkout_mode | ~control_r[tmr2_pkg::CTL_CT];
  end

  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      rdata_r <= 8'h00;
    else if (rd_i)
    begin
      if (addr_i == tmr2_pkg::ADDR_CONTROL)
        rdata_r <= control_r;
      else if (addr_i == tmr2_pkg::ADDR_MODE)
        rdata_r <= mode_r;
      else if (addr_i == tmr2_pkg::ADDR_RELOAD_LOW)
        rdata_r <= reload_r[7:0];
      else if (addr_i == tmr2_pkg::ADDR_RELOAD_HIGH)
        rdata_r <= reload_r[15:8];
      else if (addr_i == tmr2_pkg::ADDR_COUNT_LOW)
        rdata_r <= count_r[7:0];
      else if (addr_i == tmr2_pkg::ADDR_COUNT_HIGH)
        rdata_r <= count_r[15:8];
      else if (addr_i == tmr2_pkg::ADDR_IRQ_ENABLE)
        rdata_r <= ie_r;
      else
        rdata_r <= 8'h00;
    end
    else
      rdata_r <= 8'h00;
  end

  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      irq_o <= 1'b0;
    else
      irq_o <= (control_r[tmr2_pkg::CTL_OVF] | control_r[tmr2_pkg::CTL_EXF])
        & ie_r[tmr2_pkg::IE_T2] & ie_r[tmr2_pkg::IE_GLOBAL];
  end

  assign rdata_o = rdata_r;
  assign clock_output_pin_o = clk_out_r;
  assign clock_output_pin_oe_o = oe_r;
  assign tx_tick_o = tx_r;
  assign rx_tick_o = rx_r;

  baud_no_flag_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (rollover && baud_mode && !(wr_i && addr_i == tmr2_pkg::ADDR_CONTROL)
      && !control_r[tmr2_pkg::CTL_OVF]) |=> !control_r[tmr2_pkg::CTL_OVF])
    else $error("overflow flag set in baud mode");
  reload_load_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    rollover |=> count_r == $past(reload_r))
    else $error("rollover did not reload count");
  ext_flag_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (trig_fall && control_r[tmr2_pkg::CTL_EXEN]) |=> control_r[tmr2_pkg::CTL_EXF])
    else $error("external flag not set");
  run_stop_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (!control_r[tmr2_pkg::CTL_RUN] && !wr_i) |=> $stable(count_r))
    else $error("count moved while stopped");
  clk_toggle_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (clkout_mode && rollover) |=> clk_out_r != $past(clk_out_r))
    else $error("clock output missed a toggle");
  irq_gate_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    !ie_r[tmr2_pkg::IE_GLOBAL] |=> !irq_o)
    else $error("interrupt with global enable clear");
  irq_or_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (control_r[tmr2_pkg::CTL_EXF] && ie_r[tmr2_pkg::IE_T2] && ie_r[tmr2_pkg::IE_GLOBAL]) |=> irq_o)
    else $error("external flag gave no request");
  tx_tick_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    tx_tick_o |-> $past(rollover) && $past(control_r[tmr2_pkg::CTL_TRANSMIT_RATE_SELECT]))
    else $error("tx tick without rollover");
  state_rate_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (baud_mode && control_r[tmr2_pkg::CTL_RUN] && $past(control_r[tmr2_pkg::CTL_RUN]) && !wr_i
      && count_r != 16'hFFFF && pre_r == pre_lim) |=> count_r == $past(count_r) + 16'h0001)
    else $error("baud count not at state rate");
  clkout_no_flag_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (rollover && clkout_mode && !(wr_i && addr_i == tmr2_pkg::ADDR_CONTROL)
      && !control_r[tmr2_pkg::CTL_OVF]) |=> !control_r[tmr2_pkg::CTL_OVF])
    else $error("overflow flag set in clock-out mode");
  plain_flag_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (rollover && !baud_mode && !clkout_mode) |=> control_r[tmr2_pkg::CTL_OVF])
    else $error("plain rollover did not set overflow flag");
  irq_enable_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    !ie_r[tmr2_pkg::IE_T2] |=> !irq_o)
    else $error("interrupt with timer enable clear");
  rx_tick_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    rx_tick_o |-> $past(rollover) && $past(control_r[tmr2_pkg::CTL_RCLK]))
    else $error("rx tick without rollover");
  tx_due_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (rollover && control_r[tmr2_pkg::CTL_TRANSMIT_RATE_SELECT]) |=> tx_tick_o)
    else $error("rollover gave no tx tick");
  pin_port_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    !clkout_mode |=> clock_output_pin_o == $past(port_latch_i))
    else $error("pin not showing port latch");
  clk_hold_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (clkout_mode && !rollover) |=> clk_out_r == $past(clk_out_r))
    else $error("clock output moved between rollovers");
  ovf_irq_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (control_r[tmr2_pkg::CTL_OVF] && ie_r[tmr2_pkg::IE_T2] && ie_r[tmr2_pkg::IE_GLOBAL]) |=> irq_o)
    else $error("overflow flag gave no request");
  flag_hold_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (control_r[tmr2_pkg::CTL_OVF] && !(wr_i && addr_i == tmr2_pkg::ADDR_CONTROL)) |=> control_r[tmr2_pkg::CTL_OVF])
    else $error("overflow flag cleared by hardware");
  oe_drive_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    clkout_mode |=> clock_output_pin_oe_o)
    else $error("clock pin not driven in clock-out mode");
  baud_both_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (rollover && control_r[tmr2_pkg::CTL_TRANSMIT_RATE_SELECT] && clkout_mode) |=> tx_tick_o && clk_out_r != $past(clk_out_r))
    else $error("shared reload did not feed both uses");
  stop_no_tick_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    !control_r[tmr2_pkg::CTL_RUN] |=> !tx_tick_o && !rx_tick_o)
    else $error("tick while stopped");
  timer_rate_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (mode_now == tmr2_pkg::MODE_TIMER && !control_r[tmr2_pkg::CTL_CT] && pre_r != pre_lim) |-> !inc)
    else $error("plain timer counted off the machine cycle");
  count_edge_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (mode_now == tmr2_pkg::MODE_TIMER && control_r[tmr2_pkg::CTL_CT] && !(cnt_d_r && !count_pin_i)) |-> !inc)
    else $error("counter moved without a falling edge");
  ext_no_reload_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (trig_fall && baud_mode && !inc && !wr_i) |=> $stable(count_r))
    else $error("trigger edge reloaded the count");
  baud_cov: cover property (@(posedge clk_i) disable iff (!rst_b_i) rollover && baud_mode);
  ext_cov: cover property (@(posedge clk_i) disable iff (!rst_b_i) trig_fall && control_r[tmr2_pkg::CTL_EXEN]);
  both_cov: cover property (@(posedge clk_i) disable iff (!rst_b_i) clkout_mode && baud_mode && rollover);
  clk_cov: cover property (@(posedge clk_i) disable iff (!rst_b_i) clkout_mode && rollover);
  irq_cov: cover property (@(posedge clk_i) disable iff (!rst_b_i) $rose(irq_o));
endmodule : tmr2_baud_clkout

/* File: design/tmr2_pkg.sv */
// Purpose: shared constants for the baud / clock-out timer block
// Assumes: one clock at 125 MHz, registers on a plain strobe port
// Notes: offsets are word indices on the plain port
package tmr2_pkg;
  localparam logic [2:0] ADDR_CONTROL = 3'h0;
  localparam logic [2:0] ADDR_MODE = 3'h1;
  localparam logic [2:0] ADDR_RELOAD_LOW = 3'h2;
  localparam logic [2:0] ADDR_RELOAD_HIGH = 3'h3;
  localparam logic [2:0] ADDR_COUNT_LOW = 3'h4;
  localparam logic [2:0] ADDR_COUNT_HIGH = 3'h5;
  localparam logic [2:0] ADDR_IRQ_ENABLE = 3'h6;
  // control register fields
  localparam int CTL_OVF = 7;
  localparam int CTL_EXF = 6;
  localparam int CTL_RCLK = 5;
  localparam int CTL_TRANSMIT_RATE_SELECT = 4;
  localparam int CTL_EXEN = 3;
  localparam int CTL_RUN = 2;
  localparam int CTL_CT = 1;
  // mode register field
  localparam int MOD_OE = 1;
  // irq enable register fields
  localparam int IE_GLOBAL = 7;
  localparam int IE_T2 = 5;
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] MODE_RESET = 8'h00;
  localparam logic [7:0] IE_RESET = 8'h00;
  localparam logic [15:0] RELOAD_RESET = 16'h0000;
  // state time = 2 oscillator periods, machine cycle = 12
  localparam int STATE_TIME_OSC = 2;
  localparam int MACHINE_CYCLE_OSC = 12;
  typedef enum logic [1:0] {
    MODE_OFF = 2'b00,
    MODE_TIMER = 2'b01,
    MODE_BAUD = 2'b10
  } run_mode_t;
endpackage : tmr2_pkg

/* File: dv/serial_port_model.sv */
// Purpose: serial-port and pin side model, measures tick spacing and pin half periods
// Assumes: ticks are one-cycle pulses on clk_i
// Notes: gaps are in clk_i cycles; counts wrap silently
`timescale 1ns/1ps
module serial_port_model (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic tx_tick_i,
  input wire logic rx_tick_i,
  input wire logic pin_i,
  output logic [15:0] tx_gap_o,
  output logic [15:0] rx_gap_o,
  output logic [15:0] half_o,
  output logic [15:0] rx_cnt_o
);
  logic [15:0] tx_age_r;
  logic [15:0] rx_age_r;
  logic [15:0] pin_age_r;
  logic pin_last_r;
  // each direction timed on its own tick, rates may differ
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      {tx_age_r, rx_age_r, pin_age_r, tx_gap_o, rx_gap_o, half_o, rx_cnt_o} <= '0;
      pin_last_r <= 1'b0;
    end
    else
    begin
      tx_age_r <= tx_tick_i ? 16'h0001 : tx_age_r + 16'h0001;
      rx_age_r <= rx_tick_i ? 16'h0001 : rx_age_r + 16'h0001;
      if (tx_tick_i) tx_gap_o <= tx_age_r;
      if (rx_tick_i) rx_gap_o <= rx_age_r;
      if (rx_tick_i) rx_cnt_o <= rx_cnt_o + 16'h0001;
      pin_last_r <= pin_i;
      pin_age_r <= (pin_i != pin_last_r) ? 16'h0001 : pin_age_r + 16'h0001;
      if (pin_i != pin_last_r) half_o <= pin_age_r;
    end
  end
endmodule : serial_port_model

/* File: dv/tmr2_baud_clkout_tb_top.sv */
// Purpose: self-checking bench for the baud and clock-out timer
// Assumes: reload FFF0 gives 16 steps, so 32 clocks per rollover at state rate
// Notes: count bytes are only read with the timer stopped
`timescale 1ns/1ps
module tmr2_baud_clkout_tb_top;
  logic clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic [2:0] addr_i = 3'h0;
  logic [7:0] wdata_i = 8'h00;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic ext_i = 1'b1;
  logic latch_i = 1'b1;
  logic [7:0] rdata_o;
  logic pin_o, oe_o, tx_o, rx_o, irq_o, pin_snap;
  logic [15:0] tx_gap, rx_gap, half, rx_cnt;
  int n_errors = 0;
  int n_checks = 0;
  int cyc = 0;
  always #4 clk_i = ~clk_i;
  tmr2_baud_clkout uut (.clk_i(clk_i), .rst_b_i(rst_b_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .ext_trigger_pin_i(ext_i), .count_pin_i(1'b1),
    .port_latch_i(latch_i), .clock_output_pin_o(pin_o), .clock_output_pin_oe_o(oe_o),
    .tx_tick_o(tx_o), .rx_tick_o(rx_o), .irq_o(irq_o));
  serial_port_model model (.clk_i(clk_i), .rst_b_i(rst_b_i), .tx_tick_i(tx_o), .rx_tick_i(rx_o),
    .pin_i(pin_o), .tx_gap_o(tx_gap), .rx_gap_o(rx_gap), .half_o(half), .rx_cnt_o(rx_cnt));
  task end_sim;
    $display("errors %0d checks %0d", n_errors, n_checks);
    if (n_errors == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : end_sim
  task chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask : wr
  task rd(input logic [2:0] a, input logic [7:0] exp);
    @(posedge clk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 chk({8'h00, rdata_o}, {8'h00, exp});
  endtask : rd
  task w(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : w
  task t_regs;
    rd(3'h0, 8'h00);
    rd(3'h6, 8'h00);
    wr(3'h1, 8'hFF);
    rd(3'h1, 8'h03);
    wr(3'h1, 8'h00);
    wr(3'h7, 8'hFF);
    rd(3'h7, 8'h00);
    chk({15'h0, oe_o}, 16'h0001);
    wr(3'h0, 8'h02);
    w(2);
    chk({15'h0, oe_o}, 16'h0000);
    wr(3'h0, 8'h00);
    w(2);
  endtask : t_regs
  task t_baud;
    wr(3'h2, 8'hF0);
    wr(3'h3, 8'hFF);
    wr(3'h4, 8'hF0);
    wr(3'h5, 8'hFF);
    wr(3'h6, 8'hA0);
    wr(3'h0, 8'h14);
    w(200);
    chk(tx_gap, 16'd32);
    chk(tx_gap, 16'd32);
    chk(rx_cnt, 16'h0000);
    rd(3'h0, 8'h14);
    chk({15'h0, irq_o}, 16'h0000);
    rd(3'h3, 8'hFF);
    wr(3'h0, 8'h24);
    w(200);
    chk(rx_gap, 16'd32);
    wr(3'h0, 8'h00);
    rd(3'h5, 8'hFF);
  endtask : t_baud
  task t_ext;
    wr(3'h0, 8'h2C);
    ext_i <= 1'b0;
    w(8);
    rd(3'h0, 8'h6C);
    chk({15'h0, irq_o}, 16'h0001);
    w(100);
    chk(rx_gap, 16'd32);
    wr(3'h6, 8'h20);
    w(2);
    chk({15'h0, irq_o}, 16'h0000);
    wr(3'h6, 8'h80);
    w(2);
    chk({15'h0, irq_o}, 16'h0000);
    wr(3'h6, 8'hA0);
    w(50);
    chk({15'h0, irq_o}, 16'h0001);
    wr(3'h0, 8'h2C);
    w(2);
    chk({15'h0, irq_o}, 16'h0000);
    ext_i <= 1'b1;
    wr(3'h0, 8'h00);
  endtask : t_ext
  task t_clkout;
    wr(3'h1, 8'h02);
    wr(3'h0, 8'h04);
    w(300);
    chk(half, 16'd32);
    chk({15'h0, irq_o}, 16'h0000);
    rd(3'h0, 8'h04);
    wr(3'h0, 8'h14);
    w(200);
    chk(tx_gap ^ half, 16'h0000);
    wr(3'h0, 8'h00);
    w(2);
    pin_snap = pin_o;
    w(100);
    chk({15'h0, pin_o}, {15'h0, pin_snap});
    wr(3'h1, 8'h00);
    latch_i <= 1'b0;
    w(3);
    chk({15'h0, pin_o}, 16'h0000);
    latch_i <= 1'b1;
    w(3);
    chk({15'h0, pin_o}, 16'h0001);
  endtask : t_clkout
  task t_plain;
    wr(3'h0, 8'h04);
    w(400);
    rd(3'h0, 8'h84);
    chk({15'h0, irq_o}, 16'h0001);
    wr(3'h0, 8'h00);
    w(2);
    chk({15'h0, irq_o}, 16'h0000);
  endtask : t_plain
  // hang guard, generous against roughly 1700 cycles of tests
  always @(posedge clk_i)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      n_errors++;
      end_sim;
    end
  end
  initial
  begin
    repeat (16) @(posedge clk_i);
    rst_b_i <= 1'b1;
    t_regs;
    t_baud;
    t_ext;
    t_clkout;
    t_plain;
    end_sim;
  end
endmodule : tmr2_baud_clkout_tb_top
